// *** tb/halt_standby_sva.sv ***
/*
 * checker of the halt / standby controller port behaviour.
 * assumes one clock domain, REF_CLK_I, and the asynchronous reset RST_I.
 */
`timescale 1ns/10ps
module halt_standby_sva (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // apb
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // cpu and interrupt flags
  input wire logic HALT_INSN_I,
  input wire logic CPU_CLK_EN_O,
  input wire logic CPU_RESUME_O,
  input wire logic CPU_VECTOR_O,
  input wire logic IN_HALT_O,
  input wire logic IRQ_REQ_I,
  input wire logic IRQ_MASK_FLAG_I,
  input wire logic IRQ_PRIORITY_FLAG_I,
  input wire logic IRQ_ACCEPT_ENABLE_I,
  input wire logic IN_SERVICE_PRIORITY_I,
  // clocks
  input wire logic PERIPH_CLK_RUN_I,
  input wire logic MAIN_CRYSTAL_RUN_O,
  input wire logic INTERNAL_FAST_RUN_O,
  input wire logic SUB_CRYSTAL_RUN_O,
  input wire logic WDT_CLK_EN_O,
  input wire logic ADC_EN_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // armed keeps a held request from restarting the resume count
  logic armed;
  wire  rel_ev = IN_HALT_O && !armed && IRQ_REQ_I && !IRQ_MASK_FLAG_I;
  wire  vec    = IRQ_ACCEPT_ENABLE_I &&
                 (!IRQ_PRIORITY_FLAG_I || IN_SERVICE_PRIORITY_I);
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I)
      armed <= 1'h0;
    else if (rel_ev)
      armed <= 1'h1;
    else if (!IN_HALT_O)
      armed <= 1'h0;
  end
  halt_entry_a: assert property (
    CPU_CLK_EN_O && !IN_HALT_O && HALT_INSN_I |=> IN_HALT_O && !CPU_CLK_EN_O)
    else $error("halt not entered");
  clk_gated_a: assert property (IN_HALT_O |-> !CPU_CLK_EN_O)
    else $error("cpu clock runs in halt");
  vec_resume_a: assert property (rel_ev && vec
    |-> ##[11:12] (CPU_RESUME_O && CPU_VECTOR_O))
    else $error("vectored resume late");
  next_resume_a: assert property (rel_ev && !vec
    |-> ##[4:5] (CPU_RESUME_O && !CPU_VECTOR_O))
    else $error("next instruction resume late");
  masked_hold_a: assert property (
    IN_HALT_O && !armed && IRQ_MASK_FLAG_I |=> IN_HALT_O)
    else $error("masked request left halt");
  osc_kept_a: assert property (IN_HALT_O && $past(IN_HALT_O)
    |-> $stable({MAIN_CRYSTAL_RUN_O, INTERNAL_FAST_RUN_O, SUB_CRYSTAL_RUN_O}))
    else $error("oscillator state changed in halt");
  wdt_run_a: assert property (
    !IN_HALT_O && !$past(IN_HALT_O) |-> WDT_CLK_EN_O)
    else $error("watchdog clock off while running");
  adc_off_a: assert property (!PERIPH_CLK_RUN_I [*5] |-> !ADC_EN_O)
    else $error("converter on without peripheral clock");
  reset_rel_a: assert property (
    $past(RST_I) |-> CPU_CLK_EN_O && !IN_HALT_O)
    else $error("reset did not end halt");
  apb_ready_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("apb answer not in access cycle");
  apb_err_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("apb error without ready");
  cover property (rel_ev && vec);
  cover property (rel_ev && !vec);
  cover property (IN_HALT_O && IRQ_REQ_I && IRQ_MASK_FLAG_I);
endmodule : halt_standby_sva

bind halt_standby_controller halt_standby_sva i_halt_standby_sva (.*);

// *** tb/osc_model.sv ***
/*
 * main crystal oscillator model of the clock generator side.
 * assumes run_i on clk_i; ticks are clk_i based and slower than clk/4.
 */
`timescale 1ns/10ps
module osc_model #(
  parameter int START_DLY = 40,
  parameter int HALF      = 3
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // oscillator
  input  wire logic run_i,
  output logic      started_o,
  output logic      tick_o
);
  int dly;
  int ph;
  // the tick stands low while the oscillator is not running
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly       <= 0;
      ph        <= 0;
      started_o <= 1'h0;
      tick_o    <= 1'h0;
    end else if (!run_i) begin
      dly       <= 0;
      ph        <= 0;
      started_o <= 1'h0;
      tick_o    <= 1'h0;
    end else if (dly < START_DLY) begin
      dly <= dly + 1;
    end else begin
      started_o <= 1'h1;
      ph        <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1)
        tick_o <= ~tick_o;
    end
  end
endmodule : osc_model

// *** tb/tb_top.sv ***
/*
 * self-checking bench of the halt / standby controller.
 * assumes the apb slave answers in the access cycle and the osc model.
 */
`timescale 1ns/10ps
`include "halt_standby_defines.svh"
module tb_top;
  logic REF_CLK_I = 1'h0, RST_I = 1'h1, PSEL_I = 1'h0, PENABLE_I = 1'h0;
  logic PWRITE_I = 1'h0, HALT_INSN_I = 1'h0, IRQ_REQ_I = 1'h0;
  logic [11:0] PADDR_I = 12'h000;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O;
  logic IRQ_MASK_FLAG_I = 1'h0, IRQ_PRIORITY_FLAG_I = 1'h0;
  logic IRQ_ACCEPT_ENABLE_I = 1'h0, IN_SERVICE_PRIORITY_I = 1'h0;
  logic PERIPH_CLK_RUN_I = 1'h1, PREADY_O, PSLVERR_O, CPU_CLK_EN_O;
  logic CPU_RESUME_O, CPU_VECTOR_O, IN_HALT_O, MAIN_OSC_STARTED_I;
  logic MAIN_OSC_TICK_I, MAIN_CRYSTAL_RUN_O, INTERNAL_FAST_RUN_O;
  logic SUB_CRYSTAL_RUN_O, WDT_CLK_EN_O, ADC_EN_O, IRQ_O;
  int fails = 0;
  int check_count = 0;
  always #2 REF_CLK_I = ~REF_CLK_I;
  halt_standby_controller i_halt_standby_controller (.*);
  osc_model #(.START_DLY(40), .HALF(3)) i_osc_model (
    .clk_i(REF_CLK_I), .rst_i(RST_I), .run_i(MAIN_CRYSTAL_RUN_O),
    .started_o(MAIN_OSC_STARTED_I), .tick_o(MAIN_OSC_TICK_I));
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge REF_CLK_I);
    PSEL_I   <= 1'h1;
    PWRITE_I <= wr;
    PADDR_I  <= a;
    PWDATA_I <= wd;
    @(posedge REF_CLK_I);
    PENABLE_I <= 1'h1;
    do begin
      @(posedge REF_CLK_I);
      n++;
    end while (PREADY_O !== 1'h1 && n < 50);
    if (n >= 50) begin
      fails++;
      stop_test();
    end
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I    <= 1'h0;
    PENABLE_I <= 1'h0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'h0, a, 32'h0, r, e);
  endtask : rd
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd(`HSB_WAIT_SEL_ADDR, r);
    chk("wait select reset", 32'h5, r);
    rd(`HSB_STATUS_ADDR, r);
    chk("reset release bit", 32'h1, {31'h0, r[`HSB_ST_RST_REL]});
    apb(1'h0, 12'h01C, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    wr(`HSB_STATUS_ADDR, 32'hF);
    rd(`HSB_STATUS_ADDR, r);
    chk("status cleared", 32'h0, {28'h0, r[3:0]});
  endtask : t_regs
  task automatic halt_enter();
    @(posedge REF_CLK_I);
    HALT_INSN_I <= 1'h1;
    @(posedge REF_CLK_I);
    HALT_INSN_I <= 1'h0;
    repeat (2) @(posedge REF_CLK_I);
    chk("in halt", 32'h1, {31'h0, IN_HALT_O});
    chk("cpu clock gated", 32'h0, {31'h0, CPU_CLK_EN_O});
  endtask : halt_enter
  task automatic release_irq(input logic [3:0] f, input logic v);
    int n;
    {IRQ_MASK_FLAG_I, IRQ_PRIORITY_FLAG_I} <= f[3:2];
    {IRQ_ACCEPT_ENABLE_I, IN_SERVICE_PRIORITY_I} <= f[1:0];
    IRQ_REQ_I <= 1'h1;
    @(posedge REF_CLK_I);
    IRQ_REQ_I <= 1'h0;
    n = 0;
    do begin
      @(posedge REF_CLK_I);
      n++;
    end while (CPU_RESUME_O !== 1'h1 && n < 40);
    chk("resume delay", 32'h1,
        {31'h0, v ? (n == 11 || n == 12) : (n == 4 || n == 5)});
    chk("vectored", {31'h0, v}, {31'h0, CPU_VECTOR_O});
    if (n >= 40) stop_test();
    repeat (3) @(posedge REF_CLK_I);
    chk("running again", 32'h1, {31'h0, CPU_CLK_EN_O & ~IN_HALT_O});
  endtask : release_irq
  task automatic t_halt(input logic [3:0] f, input logic v,
                        input logic [1:0] src, input logic lso);
    // crystal run bit follows src[0]: off with main proves it is forced on
    wr(`HSB_CTRL_ADDR, {28'h0, lso, src, src[0]});
    halt_enter();
    chk("watchdog clock", {31'h0, ~lso}, {31'h0, WDT_CLK_EN_O});
    chk("oscillators", {29'h0, src != 2'h2, 2'h3},
        {29'h0, MAIN_CRYSTAL_RUN_O, INTERNAL_FAST_RUN_O, SUB_CRYSTAL_RUN_O});
    release_irq(f, v);
  endtask : t_halt
  task automatic t_masked();
    logic [31:0] r;
    halt_enter();
    {IRQ_MASK_FLAG_I, IRQ_REQ_I} <= 2'h3;
    repeat (20) @(posedge REF_CLK_I);
    chk("masked hold", 32'h1, {31'h0, IN_HALT_O & ~CPU_RESUME_O});
    rd(`HSB_CLKSTATE_ADDR, r);
    chk("clock state", 32'h2E, r);
    release_irq(4'h2, 1'h1);
  endtask : t_masked
  task automatic t_adc();
    PERIPH_CLK_RUN_I <= 1'h0;
    repeat (6) @(posedge REF_CLK_I);
    chk("converter off", 32'h0, {31'h0, ADC_EN_O});
    PERIPH_CLK_RUN_I <= 1'h1;
    repeat (6) @(posedge REF_CLK_I);
    chk("converter on", 32'h1, {31'h0, ADC_EN_O});
  endtask : t_adc
  task automatic t_stab();
    logic [31:0] r;
    int          n;
    // stop the crystal first so the select is never changed mid-count
    wr(`HSB_CTRL_ADDR, 32'h2);
    repeat (8) @(posedge REF_CLK_I);
    wr(`HSB_WAIT_SEL_ADDR, 32'h1);
    rd(`HSB_PROGRESS_ADDR, r);
    chk("progress idle", 32'h0, r);
    wr(`HSB_MASK_ADDR, 32'h8);
    wr(`HSB_CTRL_ADDR, 32'h3);
    n = 0;
    do begin
      @(posedge REF_CLK_I);
      n++;
    end while (IRQ_O !== 1'h1 && n < 20000);
    chk("wait irq", 32'h1, {31'h0, IRQ_O});
    if (IRQ_O !== 1'h1) stop_test();
    // 2^11 ticks of six clocks each, plus start-up and sync slack
    chk("wait length", 32'h1,
        {31'h0, n >= 2048 * 6 && n <= 2048 * 6 + 100});
    rd(`HSB_PROGRESS_ADDR, r);
    chk("progress at select", 32'h10, r);
    wr(`HSB_MASK_ADDR, 32'h0);
    repeat (2) @(posedge REF_CLK_I);
    chk("irq masked", 32'h0, {31'h0, IRQ_O});
    wr(`HSB_CTRL_ADDR, 32'h2);
    wr(`HSB_STATUS_ADDR, 32'h8);
    wr(`HSB_MASK_ADDR, 32'h8);
    repeat (2) @(posedge REF_CLK_I);
    chk("irq cleared", 32'h0, {31'h0, IRQ_O});
  endtask : t_stab
  task automatic t_reset();
    logic [31:0] r;
    halt_enter();
    RST_I <= 1'h1;
    repeat (5) @(posedge REF_CLK_I);
    RST_I <= 1'h0;
    repeat (2) @(posedge REF_CLK_I);
    chk("reset ends halt", 32'h1, {31'h0, CPU_CLK_EN_O & ~IN_HALT_O});
    rd(`HSB_STATUS_ADDR, r);
    chk("reset status", 32'h4, {28'h0, r[3:0]});
  endtask : t_reset
  initial begin
    repeat (5) @(posedge REF_CLK_I);
    RST_I <= 1'h0;
    t_regs();
    t_halt(4'h0, 1'h0, 2'h0, 1'h0);
    t_halt(4'h2, 1'h1, 2'h1, 1'h0);
    t_halt(4'h5, 1'h0, 2'h2, 1'h0);
    t_halt(4'h6, 1'h0, 2'h0, 1'h0);
    t_halt(4'h7, 1'h1, 2'h1, 1'h1);
    t_masked();
    t_adc();
    t_stab();
    t_reset();
    stop_test();
  end
endmodule : tb_top

// *** verilog/halt_standby_controller.sv ***
/*
 * halt / standby controller: halt entry, clock gating during halt,
 * release by interrupt or reset, stabilization wait select and status,
 * apb register slave and a masked sticky interrupt.
 * assumes an apb master on REF_CLK_I, cpu and interrupt controller
 * signals on the same clock, oscillator status from another domain.
 */
`timescale 1ns/10ps
`include "halt_standby_defines.svh"

module halt_standby_controller #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_I,
  // apb slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  // cpu core
  input  wire logic              HALT_INSN_I,
  output logic                   CPU_CLK_EN_O,
  output logic                   CPU_RESUME_O,
  output logic                   CPU_VECTOR_O,
  output logic                   IN_HALT_O,
  // interrupt controller flags
  input  wire logic              IRQ_REQ_I,
  input  wire logic              IRQ_MASK_FLAG_I,
  input  wire logic              IRQ_PRIORITY_FLAG_I,
  input  wire logic              IRQ_ACCEPT_ENABLE_I,
  input  wire logic              IN_SERVICE_PRIORITY_I,
  // oscillators, from another domain
  input  wire logic              MAIN_OSC_STARTED_I,
  input  wire logic              MAIN_OSC_TICK_I,
  input  wire logic              PERIPH_CLK_RUN_I,
  // clock generator controls
  output logic                   MAIN_CRYSTAL_RUN_O,
  output logic                   INTERNAL_FAST_RUN_O,
  output logic                   SUB_CRYSTAL_RUN_O,
  output logic                   WDT_CLK_EN_O,
  output logic                   ADC_EN_O,
  // interrupt
  output logic                   IRQ_O
);

  // the highest register offset needs five address bits
  if (ADDR_W < 5) begin : g_addr_chk
    $error("halt_standby_controller: ADDR_W below 5");
  end

  localparam int ST_W = `HSB_ST_WIDTH;

  // software state
  logic [2:0]                       stab_wait_select;
  logic [3:0]                       ctrl;
  logic [ST_W-1:0]                  status;
  logic [ST_W-1:0]                  mask;
  logic [2:0]                       osc_run;
  halt_standby_pkg::cpu_clk_src_t   cpu_src;
  logic                             lso_soft_stop;

  // halt state machine
  typedef enum logic [1:0] {S_RUN, S_HALT, S_RESUME} halt_state_t;
  halt_state_t                      state;
  logic [3:0]                       resume_cnt;
  logic                             resume_vec;
  logic                             halt_ev;
  logic                             irq_rel_ev;
  logic                             rst_rel_ev;
  halt_standby_pkg::release_kind_t  rel_kind;

  // synchronisers
  logic [1:0]                       started_sync;
  logic [1:0]                       tick_sync;
  logic                             tick_prev;
  logic [1:0]                       pclk_sync;
  logic [4:0]                       progress;
  logic                             wait_done;
  logic                             wait_done_prev;

  // apb decode
  logic                             wr_acc;
  logic                             rd_acc;
  logic                             addr_hit;
  logic [ADDR_W-1:0]                a;

  assign cpu_src       = halt_standby_pkg::cpu_clk_src_t'(
                           ctrl[`HSB_CTRL_CLK_LSB +: 2]);
  assign lso_soft_stop = ctrl[`HSB_CTRL_LSO_BIT];
  assign osc_run       = {ctrl[`HSB_CTRL_RUN_BIT], 2'b11};
  assign a             = PADDR_I;
  assign wr_acc        = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_acc        = PSEL_I && !PENABLE_I && !PWRITE_I;

  function automatic logic mapped(input logic [ADDR_W-1:0] ad);
    mapped = (ad == ADDR_W'(`HSB_CTRL_ADDR))     ||
             (ad == ADDR_W'(`HSB_WAIT_SEL_ADDR)) ||
             (ad == ADDR_W'(`HSB_PROGRESS_ADDR)) ||
             (ad == ADDR_W'(`HSB_STATUS_ADDR))   ||
             (ad == ADDR_W'(`HSB_MASK_ADDR))     ||
             (ad == ADDR_W'(`HSB_IRQ_ADDR))      ||
             (ad == ADDR_W'(`HSB_CLKSTATE_ADDR));
  endfunction : mapped

  assign addr_hit = mapped(a);

  // outcome of a pending request
  function automatic halt_standby_pkg::release_kind_t decide(
    input logic mk, input logic pr, input logic ie, input logic in_service_priority);
    if (mk)
      decide = halt_standby_pkg::REL_HOLD;
    else if (!pr && ie)
      decide = halt_standby_pkg::REL_VECTOR;
    else if (pr && ie && in_service_priority)
      decide = halt_standby_pkg::REL_VECTOR;
    else
      decide = halt_standby_pkg::REL_NEXT;
  endfunction : decide

  assign rel_kind = decide(IRQ_MASK_FLAG_I, IRQ_PRIORITY_FLAG_I,
                           IRQ_ACCEPT_ENABLE_I, IN_SERVICE_PRIORITY_I);

  // oscillator inputs come from outside this clock
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      started_sync <= 2'b00;
      tick_sync    <= 2'b00;
      tick_prev    <= 1'b0;
      pclk_sync    <= 2'b00;
    end else begin
      started_sync <= {started_sync[0], MAIN_OSC_STARTED_I};
      tick_sync    <= {tick_sync[0], MAIN_OSC_TICK_I};
      tick_prev    <= tick_sync[1];
      pclk_sync    <= {pclk_sync[0], PERIPH_CLK_RUN_I};
    end
  end

  stab_counter #(
    .MAX_EXP       (16)
  ) u_stab (
    .clk_i         (REF_CLK_I),
    .rst_i         (RST_I),
    .restart_i     (!started_sync[1]),
    .osc_started_i (started_sync[1]),
    .tick_i        (tick_sync[1] && !tick_prev),
    .wait_sel_i    (stab_wait_select),
    .progress_o    (progress),
    .done_o        (wait_done)
  );

  // halt entry, release and resume timing
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state      <= S_RUN;
      resume_cnt <= 4'h0;
      resume_vec <= 1'b0;
      halt_ev    <= 1'b0;
      irq_rel_ev <= 1'b0;
      rst_rel_ev <= 1'b1;
    end else begin
      halt_ev    <= 1'b0;
      irq_rel_ev <= 1'b0;
      rst_rel_ev <= 1'b0;
      unique case (state)
        S_RUN: begin
          if (HALT_INSN_I) begin
            state   <= S_HALT;
            halt_ev <= 1'b1;
          end
        end
        S_HALT: begin
          if (IRQ_REQ_I &&
              rel_kind != halt_standby_pkg::REL_HOLD) begin
            state      <= S_RESUME;
            irq_rel_ev <= 1'b1;
            resume_vec <= (rel_kind == halt_standby_pkg::REL_VECTOR);
            resume_cnt <= (rel_kind == halt_standby_pkg::REL_VECTOR) ?
                          `HSB_VEC_RESUME_CLKS - 4'd1 :
                          `HSB_NEXT_RESUME_CLKS - 4'd1;
          end
        end
        S_RESUME: begin
          if (resume_cnt == 4'h0) begin
            state <= S_RUN;
          end else begin
            resume_cnt <= resume_cnt - 4'd1;
          end
        end
      endcase
    end
  end

  // cpu and clock generator outputs
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CPU_CLK_EN_O        <= 1'b1;
      CPU_RESUME_O        <= 1'b0;
      CPU_VECTOR_O        <= 1'b0;
      IN_HALT_O           <= 1'b0;
      MAIN_CRYSTAL_RUN_O  <= 1'b0;
      INTERNAL_FAST_RUN_O <= 1'b1;
      SUB_CRYSTAL_RUN_O   <= 1'b1;
      WDT_CLK_EN_O        <= 1'b1;
      ADC_EN_O            <= 1'b0;
    end else begin
      // clock stays off for the whole resume wait
      CPU_CLK_EN_O <= (state == S_RUN) && !HALT_INSN_I;
      CPU_RESUME_O <= (state == S_RESUME) && (resume_cnt == 4'h0);
      CPU_VECTOR_O <= (state == S_RESUME) && (resume_cnt == 4'h0) &&
                      resume_vec;
      IN_HALT_O    <= (state != S_RUN) || HALT_INSN_I;
      // the source clocking the cpu is forced on; main crystal follows its run bit, the other two always run
      MAIN_CRYSTAL_RUN_O  <= osc_run[2] ||
        (cpu_src == halt_standby_pkg::CLK_MAIN_CRYSTAL);
      INTERNAL_FAST_RUN_O <= osc_run[1] ||
        (cpu_src == halt_standby_pkg::CLK_INTERNAL_FAST);
      SUB_CRYSTAL_RUN_O   <= osc_run[0] ||
        (cpu_src == halt_standby_pkg::CLK_SUB_CRYSTAL);
      WDT_CLK_EN_O <= !(lso_soft_stop && state != S_RUN);
      ADC_EN_O     <= pclk_sync[1];
    end
  end

  // software control and wait select; changes mid-wait are software's duty
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stab_wait_select <= `HSB_WAIT_SEL_RST;
      ctrl             <= `HSB_CTRL_RST;
      mask             <= `HSB_MASK_RST;
    end else if (wr_acc) begin
      if (a == ADDR_W'(`HSB_WAIT_SEL_ADDR))
        stab_wait_select <= PWDATA_I[2:0];
      if (a == ADDR_W'(`HSB_CTRL_ADDR))
        ctrl <= PWDATA_I[3:0];
      if (a == ADDR_W'(`HSB_MASK_ADDR))
        mask <= PWDATA_I[ST_W-1:0];
    end
  end

  // sticky events; a new event wins over a write-one clear
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      status         <= '0;
      wait_done_prev <= 1'b0;
    end else begin
      wait_done_prev <= wait_done;
      status <= (status & ~((wr_acc && a == ADDR_W'(`HSB_STATUS_ADDR)) ?
                  PWDATA_I[ST_W-1:0] : '0))
              | {wait_done && !wait_done_prev, rst_rel_ev,
                 irq_rel_ev, halt_ev};
    end
  end

  // apb answer: ready in the access cycle, no wait state for any access
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      IRQ_O     <= 1'b0;
    end else begin
      IRQ_O     <= |(status & mask);
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !addr_hit;
      if (rd_acc) begin
        PRDATA_O <= 32'h0000_0000;
        if (a == ADDR_W'(`HSB_CTRL_ADDR))
          PRDATA_O <= {28'h0, ctrl};
        if (a == ADDR_W'(`HSB_WAIT_SEL_ADDR))
          PRDATA_O <= {29'h0, stab_wait_select};
        if (a == ADDR_W'(`HSB_PROGRESS_ADDR))
          PRDATA_O <= {27'h0, progress};
        if (a == ADDR_W'(`HSB_STATUS_ADDR))
          PRDATA_O <= {28'h0, status};
        if (a == ADDR_W'(`HSB_MASK_ADDR))
          PRDATA_O <= {28'h0, mask};
        if (a == ADDR_W'(`HSB_IRQ_ADDR))
          PRDATA_O <= {28'h0, status & mask};
        if (a == ADDR_W'(`HSB_CLKSTATE_ADDR))
          PRDATA_O <= {26'h0, state == S_HALT, state == S_RESUME,
                       MAIN_CRYSTAL_RUN_O, INTERNAL_FAST_RUN_O,
                       SUB_CRYSTAL_RUN_O, WDT_CLK_EN_O};
      end
    end
  end

endmodule : halt_standby_controller

// *** verilog/halt_standby_defines.svh ***
/*
 * offsets, field positions, reset values and timing counts of the
 * halt / standby controller.
 * assumes inclusion by bare name from design and bench files.
 */
`ifndef HALT_STANDBY_DEFINES_SVH
`define HALT_STANDBY_DEFINES_SVH

// register byte addresses on the apb bus
`define HSB_CTRL_ADDR        12'h000
`define HSB_WAIT_SEL_ADDR    12'h004
`define HSB_PROGRESS_ADDR    12'h008
`define HSB_STATUS_ADDR      12'h00C
`define HSB_MASK_ADDR        12'h010
`define HSB_IRQ_ADDR         12'h014
`define HSB_CLKSTATE_ADDR    12'h018

// reset values
`define HSB_WAIT_SEL_RST     3'h5
`define HSB_CTRL_RST         4'h0
`define HSB_MASK_RST         4'h0

// control register fields
`define HSB_CTRL_RUN_BIT     0
`define HSB_CTRL_CLK_LSB     1
`define HSB_CTRL_LSO_BIT     3

// status bits: halt entry, interrupt release, reset release, wait done
`define HSB_ST_HALT          0
`define HSB_ST_IRQ_REL       1
`define HSB_ST_RST_REL       2
`define HSB_ST_WAIT_DONE     3
`define HSB_ST_WIDTH         4

// resume delays after release, in cpu clocks
`define HSB_VEC_RESUME_CLKS  4'd11
`define HSB_NEXT_RESUME_CLKS 4'd4

// stabilization wait exponents
`define HSB_EXP_11           5'd11
`define HSB_EXP_13           5'd13
`define HSB_EXP_14           5'd14
`define HSB_EXP_15           5'd15
`define HSB_EXP_16           5'd16

`endif

// *** verilog/halt_standby_pkg.sv ***
/*
 * types of the halt / standby controller.
 * assumes nothing beyond a systemverilog compiler.
 */
package halt_standby_pkg;

  typedef enum logic [1:0] {
    CLK_MAIN_CRYSTAL,
    CLK_INTERNAL_FAST,
    CLK_SUB_CRYSTAL
  } cpu_clk_src_t;

  typedef enum logic [1:0] {
    REL_HOLD,
    REL_VECTOR,
    REL_NEXT
  } release_kind_t;

endpackage : halt_standby_pkg

// *** verilog/stab_counter.sv ***
/*
 * stabilization counter for the main crystal oscillator.
 * assumes osc_started_i is already synchronised to clk_i and that a
 * main crystal oscillator cycle is seen as a one-cycle tick_i pulse.
 */
`timescale 1ns/10ps
`include "halt_standby_defines.svh"

module stab_counter #(
  parameter int MAX_EXP = 16
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       restart_i,
  input  wire logic       osc_started_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] wait_sel_i,
  // status
  output logic      [4:0] progress_o,
  output logic            done_o
);

  // the count must reach the longest wait, bit MAX_EXP included
  if (MAX_EXP < 16) begin : g_exp_chk
    $error("stab_counter: MAX_EXP below 16");
  end

  logic [MAX_EXP:0]   count;
  logic [4:0]         sel_exp;

  function automatic logic [4:0] exp_of(input logic [2:0] code);
    unique case (code)
      3'h1:    exp_of = `HSB_EXP_11;
      3'h2:    exp_of = `HSB_EXP_13;
      3'h3:    exp_of = `HSB_EXP_14;
      3'h4:    exp_of = `HSB_EXP_15;
      3'h5:    exp_of = `HSB_EXP_16;
      // prohibited codes fall back to the longest wait, the safe side
      default: exp_of = `HSB_EXP_16;
    endcase
  endfunction : exp_of

  assign sel_exp = exp_of(wait_sel_i);

  // counting starts only once the oscillator really runs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (restart_i) begin
      count <= '0;
    end else if (osc_started_i && tick_i && !done_o) begin
      count <= count + 1'b1;
    end
  end

  // progress bits rise in order and stop at the selected wait
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      progress_o <= 5'h00;
      done_o     <= 1'b0;
    end else if (restart_i) begin
      progress_o <= 5'h00;
      done_o     <= 1'b0;
    end else begin
      // bit n of the count first rises after exactly 2^n ticks
      if (count[11] && sel_exp >= `HSB_EXP_11) progress_o[4] <= 1'b1;
      if (count[13] && sel_exp >= `HSB_EXP_13) progress_o[3] <= 1'b1;
      if (count[14] && sel_exp >= `HSB_EXP_14) progress_o[2] <= 1'b1;
      if (count[15] && sel_exp >= `HSB_EXP_15) progress_o[1] <= 1'b1;
      if (count[16] && sel_exp >= `HSB_EXP_16) progress_o[0] <= 1'b1;
      if (count[sel_exp] == 1'b1) done_o <= 1'b1;
    end
  end

endmodule : stab_counter
